// >>> rtl/aecb_cfg.svh
`ifndef AECB_CFG_SVH
`define AECB_CFG_SVH
// Contract
// - bit 6 set arms falling edges
// - bit 5 set arms rising edges
// - output reference level decode, default 2.048V
// - output source bit picks internal or supply
// - input reference level decode, default 1.024V
// - input source bit picks internal or supply
// - vendor id low byte, full read/write

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_OUT_CONV   12'h000
`define OFS_EDGE_CFG   12'h004
`define OFS_VID_LOW    12'h008
`define OFS_STATUS     12'h00C
`define OFS_MASK       12'h010

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define OC_LVL_HI      7
`define OC_LVL_LO      6
`define OC_SRC         5
`define OC_CODE_HI     4
`define OC_CODE_LO     0
`define EC_FALL        6
`define EC_RISE        5
`define EC_LVL_HI      4
`define EC_LVL_LO      3
`define EC_SRC         2
`define EC_WMASK       8'h7C
`define ST_RISE        0
`define ST_FALL        1
`define ST_CFG         2
`define ST_MSB         2

// ----------------------------------------------------------------
// reset values and decode constants
// ----------------------------------------------------------------
`define RST_OUT_CONV   8'h88
`define RST_EDGE_CFG   8'h6C
// arbitrary neutral vendor id low byte
`define RST_VID_LOW    8'h5A
`define RST_ZERO8      8'h00
`define RST_ZERO32     32'h0000_0000
`define SETTLE_DONE    2'h3
`define MV_4096        13'h1000
`define MV_2048        13'h0800
`define MV_1024        13'h0400
`define MV_OFF         13'h0000

`endif

// >>> rtl/aecb_pkg.sv
`default_nettype none
`include "aecb_cfg.svh"

package aecb_pkg;

    typedef enum logic [1:0] {
        REF_OFF  = 2'h0,
        REF_1024 = 2'h1,
        REF_2048 = 2'h2,
        REF_4096 = 2'h3
    } ref_level_type;

    typedef logic [`ST_MSB:0] status_type;

endpackage

`default_nettype wire

// >>> rtl/analog_edge_config_bank.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "aecb_cfg.svh"

module analog_edge_config_bank (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        EXT_INT_PIN,
    output var  logic        EDGE_EVENT,
    output var  logic        IRQ,
    output var  logic [4:0]  OUT_CONV_CODE,
    output var  logic [12:0] OUT_CONV_REF_MV,
    output var  logic        OUT_CONV_USE_INT,
    output var  logic [12:0] IN_CONV_REF_MV,
    output var  logic        IN_CONV_USE_INT,
    output var  logic [7:0]  VENDOR_ID_LOW
);

// ----------------------------------------------------------------
// reference level decode
// ----------------------------------------------------------------
    function automatic logic [12:0] ref_mv(input logic [1:0] lvl);
        aecb_pkg::ref_level_type l;
        l = aecb_pkg::ref_level_type'(lvl);
        case (l)
            aecb_pkg::REF_4096: ref_mv = `MV_4096;
            aecb_pkg::REF_2048: ref_mv = `MV_2048;
            aecb_pkg::REF_1024: ref_mv = `MV_1024;
            default:            ref_mv = `MV_OFF;
        endcase
    endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
    logic [7:0]             out_cfg_r;
    logic [7:0]             out_cfg_nxt;
    logic [7:0]             edge_cfg_r;
    logic [7:0]             edge_cfg_nxt;
    logic [7:0]             vid_r;
    logic [7:0]             vid_nxt;
    aecb_pkg::status_type   mask_r;
    aecb_pkg::status_type   mask_nxt;
    aecb_pkg::status_type   status_r;
    aecb_pkg::status_type   status_nxt;
    aecb_pkg::status_type   ev;
    aecb_pkg::status_type   rd_clr;
    logic                   pready_r;
    logic                   pready_nxt;
    logic                   pslverr_r;
    logic                   pslverr_nxt;
    logic [31:0]            prdata_r;
    logic [31:0]            prdata_nxt;
    logic                   irq_r;
    logic                   edge_ev_r;
    logic [12:0]            oc_mv_r;
    logic [12:0]            ic_mv_r;
    logic                   sync1_r;
    logic                   sync2_r;
    logic                   prev_r;
    logic [1:0]             settle_r;
    logic [1:0]             settle_nxt;

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
    wire setup     = PSEL & ~PENABLE & ~pready_r;
    wire access    = PSEL & PENABLE & pready_r;
    wire wr_acc    = access & PWRITE;
    wire rd_acc    = access & ~PWRITE;
    wire hit_out   = (PADDR == `OFS_OUT_CONV);
    wire hit_edge  = (PADDR == `OFS_EDGE_CFG);
    wire hit_vid   = (PADDR == `OFS_VID_LOW);
    wire hit_stat  = (PADDR == `OFS_STATUS);
    wire hit_mask  = (PADDR == `OFS_MASK);
    wire mapped    = hit_out | hit_edge | hit_vid | hit_stat | hit_mask;
    wire wr_out    = wr_acc & hit_out;
    wire wr_edge   = wr_acc & hit_edge;
    wire wr_vid    = wr_acc & hit_vid;
    wire wr_mask   = wr_acc & hit_mask;

    wire [7:0] rd_mux =
        hit_out  ? out_cfg_r :
        hit_edge ? edge_cfg_r :
        hit_vid  ? vid_r :
        hit_stat ? {5'h00, status_r} :
        hit_mask ? {5'h00, mask_r} :
                   `RST_ZERO8;

    assign pready_nxt  = setup;
    assign pslverr_nxt = setup & ~mapped;
    assign prdata_nxt  = (setup & ~PWRITE) ? {24'h00_0000, rd_mux}
                                           : `RST_ZERO32;

// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
    // code, source and level written as one byte
    assign out_cfg_nxt = wr_out ? PWDATA[7:0] : out_cfg_r;
    // reserved bits are held at zero whatever software sends
    assign edge_cfg_nxt = wr_edge ? (PWDATA[7:0] & `EC_WMASK)
                                  : edge_cfg_r;
    assign vid_nxt  = wr_vid ? PWDATA[7:0] : vid_r;
    assign mask_nxt = wr_mask ? PWDATA[`ST_MSB:0] : mask_r;

// ----------------------------------------------------------------
// external pin edge detector
// ----------------------------------------------------------------
    // edges are ignored until the synchroniser has filled, so a
    // pin that is high at reset release does not fake a rise
    wire settled = (settle_r == `SETTLE_DONE);
    assign settle_nxt = settled ? settle_r : settle_r + 2'h1;
    wire rise = settled & sync2_r & ~prev_r;
    wire fall = settled & ~sync2_r & prev_r;

    assign ev[`ST_RISE] = rise & edge_cfg_r[`EC_RISE];
    assign ev[`ST_FALL] = fall & edge_cfg_r[`EC_FALL];
    assign ev[`ST_CFG]  = wr_out | wr_edge | wr_vid;

// ----------------------------------------------------------------
// interrupt status
// ----------------------------------------------------------------
    // only bits actually returned to software are cleared, so an
    // event landing between setup and access is not lost
    assign rd_clr = (rd_acc & hit_stat) ? prdata_r[`ST_MSB:0]
                                        : 3'h0;
    assign status_nxt = (status_r & ~rd_clr) | ev;

// ----------------------------------------------------------------
// flops
// ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            out_cfg_r  <= `RST_OUT_CONV;
            edge_cfg_r <= `RST_EDGE_CFG;
            vid_r      <= `RST_VID_LOW;
            mask_r     <= 3'h0;
            status_r   <= 3'h0;
        end
        else
        begin
            out_cfg_r  <= out_cfg_nxt;
            edge_cfg_r <= edge_cfg_nxt;
            vid_r      <= vid_nxt;
            mask_r     <= mask_nxt;
            status_r   <= status_nxt;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `RST_ZERO32;
        end
        else
        begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            sync1_r  <= 1'b0;
            sync2_r  <= 1'b0;
            prev_r   <= 1'b0;
            settle_r <= 2'h0;
        end
        else
        begin
            sync1_r  <= EXT_INT_PIN;
            sync2_r  <= sync1_r;
            prev_r   <= sync2_r;
            settle_r <= settle_nxt;
        end
    end

    // outputs registered from next values to stay aligned
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            irq_r     <= 1'b0;
            edge_ev_r <= 1'b0;
            oc_mv_r   <= `MV_2048;
            ic_mv_r   <= `MV_1024;
        end
        else
        begin
            irq_r     <= |(status_nxt & mask_nxt);
            edge_ev_r <= ev[`ST_RISE] | ev[`ST_FALL];
            oc_mv_r   <= ref_mv(out_cfg_nxt[`OC_LVL_HI:`OC_LVL_LO]);
            ic_mv_r   <= ref_mv(edge_cfg_nxt[`EC_LVL_HI:`EC_LVL_LO]);
        end
    end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
    assign PRDATA           = prdata_r;
    assign PREADY           = pready_r;
    assign PSLVERR          = pslverr_r;
    assign IRQ              = irq_r;
    assign EDGE_EVENT       = edge_ev_r;
    assign OUT_CONV_CODE    = out_cfg_r[`OC_CODE_HI:`OC_CODE_LO];
    assign OUT_CONV_REF_MV  = oc_mv_r;
    assign OUT_CONV_USE_INT = out_cfg_r[`OC_SRC];
    assign IN_CONV_REF_MV   = ic_mv_r;
    assign IN_CONV_USE_INT  = edge_cfg_r[`EC_SRC];
    assign VENDOR_ID_LOW    = vid_r;

// ----------------------------------------------------------------
// assertions
// ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_wr_out;
        wr_out;
    endsequence

    sequence s_wr_edge;
        wr_edge;
    endsequence

    sequence s_wr_vid;
        wr_vid;
    endsequence

    sequence s_apb_xfer;
        setup ##1 (PREADY && PSEL && PENABLE);
    endsequence

    a_fall_arm: assert property (
        (fall && edge_cfg_r[`EC_FALL]) |=>
            (status_r[`ST_FALL] && EDGE_EVENT))
        else $error("armed falling edge not flagged");

    a_fall_ignore: assert property (
        (fall && !edge_cfg_r[`EC_FALL]) |=> !EDGE_EVENT)
        else $error("disarmed falling edge triggered");

    a_rise_arm: assert property (
        (rise && edge_cfg_r[`EC_RISE]) |=>
            (status_r[`ST_RISE] && EDGE_EVENT))
        else $error("armed rising edge not flagged");

    a_rise_ignore: assert property (
        (rise && !edge_cfg_r[`EC_RISE]) |=> !EDGE_EVENT)
        else $error("disarmed rising edge triggered");

    a_oc_level: assert property (
        s_wr_out |=> (OUT_CONV_REF_MV ==
            ($past(PWDATA[`OC_LVL_HI:`OC_LVL_LO]) == 2'h3 ? `MV_4096 :
             $past(PWDATA[`OC_LVL_HI:`OC_LVL_LO]) == 2'h2 ? `MV_2048 :
             $past(PWDATA[`OC_LVL_HI:`OC_LVL_LO]) == 2'h1 ? `MV_1024 :
                                                            `MV_OFF)))
        else $error("output reference level decode wrong");

    a_oc_source: assert property (
        s_wr_out |=> (OUT_CONV_USE_INT == $past(PWDATA[`OC_SRC])))
        else $error("output reference source not applied");

    a_ic_level: assert property (
        s_wr_edge |=> (IN_CONV_REF_MV ==
            ($past(PWDATA[`EC_LVL_HI:`EC_LVL_LO]) == 2'h3 ? `MV_4096 :
             $past(PWDATA[`EC_LVL_HI:`EC_LVL_LO]) == 2'h2 ? `MV_2048 :
             $past(PWDATA[`EC_LVL_HI:`EC_LVL_LO]) == 2'h1 ? `MV_1024 :
                                                            `MV_OFF)))
        else $error("input reference level decode wrong");

    a_ic_source: assert property (
        s_wr_edge |=> (IN_CONV_USE_INT == $past(PWDATA[`EC_SRC])))
        else $error("input reference source not applied");

    a_rsvd_zero: assert property (
        s_wr_edge |=> ((edge_cfg_r & ~`EC_WMASK) == `RST_ZERO8))
        else $error("reserved edge config bits not zero");

    a_vid_hold: assert property (
        s_wr_vid |=> (VENDOR_ID_LOW == $past(PWDATA[7:0]))
            ##1 $stable(VENDOR_ID_LOW) || wr_vid)
        else $error("vendor id low byte not stored");

    a_code_drive: assert property (
        s_wr_out |=> (OUT_CONV_CODE ==
            $past(PWDATA[`OC_CODE_HI:`OC_CODE_LO])))
        else $error("output code not applied");

    a_apb_answer: assert property (
        s_apb_xfer |=> !PREADY)
        else $error("ready not a single access cycle");

    a_irq_level: assert property (
        IRQ == |(status_r & mask_r))
        else $error("interrupt level mismatch");

    sequence s_stat_rd;
        rd_acc && hit_stat;
    endsequence

    a_cfg_flag: assert property (
        (wr_out || wr_edge || wr_vid) |=> status_r[`ST_CFG])
        else $error("config write not flagged");

    a_rise_rd_clear: assert property (
        s_stat_rd ##0 (prdata_r[`ST_RISE] && !ev[`ST_RISE])
            |=> !status_r[`ST_RISE])
        else $error("read did not clear rise flag");

    a_fall_rd_clear: assert property (
        s_stat_rd ##0 (prdata_r[`ST_FALL] && !ev[`ST_FALL])
            |=> !status_r[`ST_FALL])
        else $error("read did not clear fall flag");

    a_cfg_rd_clear: assert property (
        s_stat_rd ##0 (prdata_r[`ST_CFG] && !ev[`ST_CFG])
            |=> !status_r[`ST_CFG])
        else $error("read did not clear config flag");

    a_bad_addr: assert property (
        (setup && !mapped) |=> (PREADY && PSLVERR && PRDATA == `RST_ZERO32))
        else $error("unmapped access not refused");

    a_bad_wr_keep: assert property (
        (wr_acc && !mapped) |=> ($stable(out_cfg_r) && $stable(edge_cfg_r)
            && $stable(vid_r) && $stable(mask_r)))
        else $error("unmapped write changed a register");

    a_idle_quiet: assert property (
        !PREADY |-> (PRDATA == `RST_ZERO32 && !PSLVERR))
        else $error("read data or error outside access");

    a_mask_store: assert property (
        wr_mask |=> (mask_r == $past(PWDATA[`ST_MSB:0])))
        else $error("mask write not stored");

endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "aecb_cfg.svh"

module testbench;
    logic        SYS_CLK     = 1'b0;
    logic        RST         = 1'b1;
    logic        PSEL        = 1'b0;
    logic        PENABLE     = 1'b0;
    logic        PWRITE      = 1'b0;
    logic [11:0] PADDR       = 12'h000;
    logic [31:0] PWDATA      = 32'h0000_0000;
    logic        EXT_INT_PIN = 1'b0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        EDGE_EVENT;
    logic        IRQ;
    logic [4:0]  OUT_CONV_CODE;
    logic [12:0] OUT_CONV_REF_MV;
    logic        OUT_CONV_USE_INT;
    logic [12:0] IN_CONV_REF_MV;
    logic        IN_CONV_USE_INT;
    logic [7:0]  VENDOR_ID_LOW;
    int          n_mismatch  = 0;
    int          compares    = 0;
    logic [12:0] mv_tab [4]  = '{`MV_OFF, `MV_1024, `MV_2048, `MV_4096};

    analog_edge_config_bank u_analog_edge_config_bank (
        .SYS_CLK          (SYS_CLK),
        .RST              (RST),
        .PSEL             (PSEL),
        .PENABLE          (PENABLE),
        .PWRITE           (PWRITE),
        .PADDR            (PADDR),
        .PWDATA           (PWDATA),
        .PRDATA           (PRDATA),
        .PREADY           (PREADY),
        .PSLVERR          (PSLVERR),
        .EXT_INT_PIN      (EXT_INT_PIN),
        .EDGE_EVENT       (EDGE_EVENT),
        .IRQ              (IRQ),
        .OUT_CONV_CODE    (OUT_CONV_CODE),
        .OUT_CONV_REF_MV  (OUT_CONV_REF_MV),
        .OUT_CONV_USE_INT (OUT_CONV_USE_INT),
        .IN_CONV_REF_MV   (IN_CONV_REF_MV),
        .IN_CONV_USE_INT  (IN_CONV_USE_INT),
        .VENDOR_ID_LOW    (VENDOR_ID_LOW)
    );

    always #5 SYS_CLK = ~SYS_CLK;

    // ------------------------------------------------------------
    // report and bus tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // master holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge SYS_CLK);
        end
        cmp(32'(PREADY), 32'h0000_0001);
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d,
                          input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        cmp(32'(er), 32'(exp_err));
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, rd, er);
        cmp(rd, exp);
        cmp(32'(er), 32'(exp_err));
    endtask

    // drives the pin and counts event pulses over the detector latency
    task automatic pin_to(input logic v, input int exp_events);
        int k;
        k = 0;
        @(posedge SYS_CLK);
        EXT_INT_PIN <= v;
        repeat (8)
        begin
            @(posedge SYS_CLK);
            if (EDGE_EVENT === 1'b1)
                k++;
        end
        cmp(32'(k), 32'(exp_events));
    endtask

    task automatic settle();
        repeat (3) @(posedge SYS_CLK);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd_chk(`OFS_OUT_CONV, 32'h0000_0088, 1'b0);
        rd_chk(`OFS_EDGE_CFG, 32'h0000_006C, 1'b0);
        rd_chk(`OFS_VID_LOW, 32'h0000_005A, 1'b0);
        rd_chk(`OFS_MASK, 32'h0000_0000, 1'b0);
        cmp(32'(OUT_CONV_CODE), 32'h0000_0008);
        cmp(32'(OUT_CONV_REF_MV), 32'(`MV_2048));
        cmp(32'(OUT_CONV_USE_INT), 32'h0000_0000);
        cmp(32'(IN_CONV_REF_MV), 32'(`MV_1024));
        cmp(32'(IN_CONV_USE_INT), 32'h0000_0001);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`OFS_OUT_CONV, 32'({i[1:0], i[0], 5'(i * 9 + 1)}), 1'b0);
            wr_reg(`OFS_EDGE_CFG, 32'({3'h3, i[1:0], ~i[0], 2'h0}), 1'b0);
            settle();
            cmp(32'(OUT_CONV_REF_MV), 32'(mv_tab[i]));
            cmp(32'(OUT_CONV_USE_INT), 32'(i[0]));
            cmp(32'(OUT_CONV_CODE), 32'(i * 9 + 1));
            cmp(32'(IN_CONV_REF_MV), 32'(mv_tab[i]));
            cmp(32'(IN_CONV_USE_INT), 32'(!i[0]));
        end
        $display("reference decode done");
        // reserved bits are masked by hardware, so software slips are harmless
        wr_reg(`OFS_EDGE_CFG, 32'h0000_00FF, 1'b0);
        rd_chk(`OFS_EDGE_CFG, 32'h0000_007C, 1'b0);
        wr_reg(`OFS_VID_LOW, 32'h0000_00A5, 1'b0);
        rd_chk(`OFS_VID_LOW, 32'h0000_00A5, 1'b0);
        wr_reg(12'h020, 32'h0000_0011, 1'b1);
        rd_chk(12'h014, 32'h0000_0000, 1'b1);
        settle();
        cmp(32'(VENDOR_ID_LOW), 32'h0000_00A5);
        $display("access kinds done");
        wr_reg(`OFS_MASK, 32'h0000_0003, 1'b0);
        wr_reg(`OFS_EDGE_CFG, 32'h0000_002C, 1'b0);
        rd_chk(`OFS_STATUS, 32'h0000_0004, 1'b0);
        cmp(32'(IRQ), 32'h0000_0000);
        pin_to(1'b1, 1);
        cmp(32'(IRQ), 32'h0000_0001);
        pin_to(1'b0, 0);
        rd_chk(`OFS_STATUS, 32'h0000_0001, 1'b0);
        settle();
        cmp(32'(IRQ), 32'h0000_0000);
        rd_chk(`OFS_STATUS, 32'h0000_0000, 1'b0);
        wr_reg(`OFS_EDGE_CFG, 32'h0000_004C, 1'b0);
        rd_chk(`OFS_STATUS, 32'h0000_0004, 1'b0);
        pin_to(1'b1, 0);
        pin_to(1'b0, 1);
        rd_chk(`OFS_STATUS, 32'h0000_0002, 1'b0);
        wr_reg(`OFS_MASK, 32'h0000_0000, 1'b0);
        wr_reg(`OFS_EDGE_CFG, 32'h0000_006C, 1'b0);
        pin_to(1'b1, 1);
        pin_to(1'b0, 1);
        cmp(32'(IRQ), 32'h0000_0000);
        rd_chk(`OFS_STATUS, 32'h0000_0007, 1'b0);
        $display("edge interrupts done");
        final_report();
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        #200000;
        n_mismatch++;
        final_report();
    end
endmodule

`default_nettype wire
